// ==== core/cmbc_consts.svh ====
// offsets, field positions, limits and codes of the mode/buffer control
`ifndef CMBC_CONSTS_SVH
`define CMBC_CONSTS_SVH

`define CMBC_OFS_CTRL1   8'h00
`define CMBC_OFS_CTRL2   8'h04
`define CMBC_OFS_VEC     8'h08
`define CMBC_OFS_FCTRL   8'h0C

`define CMBC_BIT_STOPIDL 13
`define CMBC_BIT_ABORT   12
`define CMBC_BIT_CLKSEL  11
`define CMBC_POS_REQ     8
`define CMBC_POS_CUR     5
`define CMBC_BIT_CAP     3
`define CMBC_BIT_WIN     0
`define CMBC_POS_HIT     8
`define CMBC_POS_DMA_BUFFER_COUNT   13

`define CMBC_MODE_NORMAL 3'h0
`define CMBC_MODE_DIS    3'h1
`define CMBC_MODE_LOOP   3'h2
`define CMBC_MODE_LISTEN 3'h3
`define CMBC_MODE_CFG    3'h4
`define CMBC_MODE_RES5   3'h5
`define CMBC_MODE_RES6   3'h6
`define CMBC_MODE_LALL   3'h7

`define CMBC_IDLE_BITS   4'hB
`define CMBC_DATA_COMPARE_COUNT_MAX   5'h11
`define CMBC_DMA_BUFFER_COUNT_RES   3'h7
`define CMBC_MAX_DLC     4'h8

`define CMBC_IC_NONE     7'h40
`define CMBC_IC_ERR      7'h41
`define CMBC_IC_WAKE     7'h42
`define CMBC_IC_OVF      7'h43
`define CMBC_IC_FIFO     7'h44

`define CMBC_WAKE_LEN    8'h08

`endif

// ==== core/cmbc_pkg.sv ====
// state types of the mode and buffer control block
package cmbc_pkg;

  typedef struct packed {
    logic       rx_s1;
    logic       rx_s2;
    logic [3:0] idle_cnt;
    logic       stop_idle;
    logic       abort;
    logic       clk_dbl;
    logic [2:0] req;
    logic [2:0] cur;
    logic       cap_en;
    logic       map_window_select;
    logic [4:0] data_compare_count;
    logic [4:0] hit;
    logic [6:0] interrupt_code;
    logic [2:0] dma_buffer_count;
    logic [5:0] fifo_start_buffer;
    logic       ack;
    logic [15:0] rdat;
    logic       halt;
    logic       cap_evt;
    logic       rtr_req;
    logic [3:0] rx_len;
    logic       wake_evt;
  } cmbc_ctrl_st_type;

  typedef struct packed {
    logic [7:0] cnt;
    logic       fired;
    logic       wake;
  } cmbc_wake_st_type;

endpackage

// ==== core/cmbc_wake_if.sv ====
// link between the control block and its wake-up low-pass filter
`timescale 1ns/100ps
`default_nettype none
interface cmbc_wake_if;
  logic rx_level;
  logic arm;
  logic wake;
  modport ctrl (output rx_level, output arm, input wake);
  modport filt (input rx_level, input arm, output wake);
endinterface
`default_nettype wire

// ==== core/cmbc_wake_filter.sv ====
// wake-up detector: dominant level must persist before it counts as activity
`timescale 1ns/100ps
`default_nettype none
`include "cmbc_consts.svh"
module cmbc_wake_filter
  import cmbc_pkg::*;
#(
  parameter logic [7:0] WAKE_LEN = `CMBC_WAKE_LEN
) (
  input  wire logic  i_clk,
  input  wire logic  i_rst,
  cmbc_wake_if.filt  wk
);

  cmbc_wake_st_type st_r;
  cmbc_wake_st_type st_nxt;

  // short glitches restart the count, so only a held dominant level wakes
  always_comb begin
    st_nxt = st_r;
    st_nxt.wake = 1'b0;
    if (!wk.arm || wk.rx_level) begin
      st_nxt.cnt = 8'h00;
      st_nxt.fired = 1'b0;
    end else if (!st_r.fired) begin
      if (st_r.cnt == WAKE_LEN - 8'h01) begin
        st_nxt.wake = 1'b1;
        st_nxt.fired = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wk.wake = st_r.wake;

  a_wake_needs_dominant: assert property (@(posedge i_clk) disable iff (i_rst)
    st_r.wake |-> $past(!wk.rx_level && wk.arm))
    else $error("wake without held dominant level");

endmodule
`default_nettype wire

// ==== core/cmbc_ctrl.sv ====
// mode, abort, clocking and buffer control registers of the CAN controller
`timescale 1ns/100ps
`default_nettype none
`include "cmbc_consts.svh"
module cmbc_ctrl
  import cmbc_pkg::*;
#(
  parameter int         NUM_TX   = 8,
  parameter int         NUM_IRQB = 16,
  parameter logic [7:0] WAKE_LEN = `CMBC_WAKE_LEN
) (
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  input  wire logic                i_wb_cyc,
  input  wire logic                i_wb_stb,
  input  wire logic                i_wb_we,
  input  wire logic [7:0]          i_wb_adr,
  input  wire logic [31:0]         i_wb_dat,
  input  wire logic [3:0]          i_wb_sel,
  output logic [31:0]              o_wb_dat,
  output logic                     o_wb_ack,
  input  wire logic                i_can_rx,
  input  wire logic                i_bit_tick,
  input  wire logic                i_cpu_idle,
  input  wire logic [NUM_TX-1:0]   i_tx_pending,
  input  wire logic                i_rx_msg_done,
  input  wire logic                i_msg_ok,
  input  wire logic                i_rx_rtr,
  input  wire logic [3:0]          i_rx_dlc,
  input  wire logic                i_hit_valid,
  input  wire logic [3:0]          i_hit_num,
  input  wire logic [NUM_IRQB-1:0] i_buf_irq,
  input  wire logic                i_err_irq,
  input  wire logic                i_wake_irq,
  input  wire logic                i_ovf_irq,
  input  wire logic                i_fifo_irq,
  output logic [2:0]               o_current_mode,
  output logic                     o_halt,
  output logic                     o_abort_all,
  output logic                     o_clk_double,
  output logic                     o_capture_evt,
  output logic                     o_window_filter,
  output logic [4:0]               o_compare_bits,
  output logic [5:0]               o_buffer_count,
  output logic [5:0]               o_fifo_start,
  output logic                     o_rtr_reply,
  output logic [3:0]               o_rx_len,
  output logic                     o_wake_evt
);

  cmbc_ctrl_st_type st_r;
  cmbc_ctrl_st_type st_nxt;
  cmbc_wake_if      wk ();

  function automatic logic mode_reserved(input logic [2:0] m);
    return (m == `CMBC_MODE_RES5) || (m == `CMBC_MODE_RES6);
  endfunction

  // fixed priority: special sources first, then lowest buffer number
  function automatic logic [6:0] interrupt_code_of(
    input logic                e,
    input logic                w,
    input logic                o,
    input logic                f,
    input logic [NUM_IRQB-1:0] b
  );
    logic [6:0] c;
    c = `CMBC_IC_NONE;
    if (e) begin
      c = `CMBC_IC_ERR;
    end else if (w) begin
      c = `CMBC_IC_WAKE;
    end else if (o) begin
      c = `CMBC_IC_OVF;
    end else if (f) begin
      c = `CMBC_IC_FIFO;
    end else begin
      for (int i = NUM_IRQB - 1; i >= 0; i--) begin
        if (b[i]) begin
          c = 7'(i);
        end
      end
    end
    return c;
  endfunction

  function automatic logic [5:0] buf_count_of(input logic [2:0] code);
    logic [5:0] n;
    unique case (code)
      3'h0: n = 6'h04;
      3'h1: n = 6'h06;
      3'h2: n = 6'h08;
      3'h3: n = 6'h0C;
      3'h4: n = 6'h10;
      3'h5: n = 6'h18;
      3'h6: n = 6'h20;
      3'h7: n = 6'h20;
    endcase
    return n;
  endfunction

  logic        bus_idle;
  logic        wb_req;
  logic        wr_lo;
  logic        wr_hi;
  logic [15:0] wd;
  logic [15:0] rd;
  logic        mapped;

  assign bus_idle = (st_r.idle_cnt == `CMBC_IDLE_BITS);
  assign wb_req   = i_wb_cyc && i_wb_stb;
  // a write takes effect on the edge where the master sees ack
  assign wr_lo    = wb_req && i_wb_we && st_r.ack && i_wb_sel[0];
  assign wr_hi    = wb_req && i_wb_we && st_r.ack && i_wb_sel[1];
  assign wd       = i_wb_dat[15:0];

  always_comb begin
    mapped = 1'b1;
    rd = 16'h0000;
    unique case (i_wb_adr)
      `CMBC_OFS_CTRL1: begin
        rd[`CMBC_BIT_STOPIDL] = st_r.stop_idle;
        rd[`CMBC_BIT_ABORT] = st_r.abort;
        rd[`CMBC_BIT_CLKSEL] = st_r.clk_dbl;
        rd[`CMBC_POS_REQ +: 3] = st_r.req;
        rd[`CMBC_POS_CUR +: 3] = st_r.cur;
        rd[`CMBC_BIT_CAP] = st_r.cap_en;
        rd[`CMBC_BIT_WIN] = st_r.map_window_select;
      end
      `CMBC_OFS_CTRL2: rd[4:0] = st_r.data_compare_count;
      `CMBC_OFS_VEC: begin
        rd[`CMBC_POS_HIT +: 5] = st_r.hit;
        rd[6:0] = st_r.interrupt_code;
      end
      `CMBC_OFS_FCTRL: begin
        rd[`CMBC_POS_DMA_BUFFER_COUNT +: 3] = st_r.dma_buffer_count;
        rd[5:0] = st_r.fifo_start_buffer;
      end
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.rx_s1 = i_can_rx;
    st_nxt.rx_s2 = st_r.rx_s1;

    // recessive-bit run length, saturating at the idle threshold
    if (!st_r.rx_s2) begin
      st_nxt.idle_cnt = 4'h0;
    end else if (i_bit_tick && !bus_idle) begin
      st_nxt.idle_cnt = st_r.idle_cnt + 4'h1;
    end

    // wishbone classic: ack one cycle after request, dropped next cycle
    st_nxt.ack = wb_req && !st_r.ack;
    if (wb_req && !st_r.ack) begin
      st_nxt.rdat = mapped ? rd : 16'h0000;
    end

    if (wr_hi && mapped) begin
      if (i_wb_adr == `CMBC_OFS_CTRL1) begin
        st_nxt.stop_idle = wd[`CMBC_BIT_STOPIDL];
        st_nxt.clk_dbl = wd[`CMBC_BIT_CLKSEL];
        st_nxt.req = wd[`CMBC_POS_REQ +: 3];
      end
      if (i_wb_adr == `CMBC_OFS_FCTRL &&
          wd[`CMBC_POS_DMA_BUFFER_COUNT +: 3] != `CMBC_DMA_BUFFER_COUNT_RES) begin
        st_nxt.dma_buffer_count = wd[`CMBC_POS_DMA_BUFFER_COUNT +: 3];
      end
    end
    if (wr_lo && mapped) begin
      if (i_wb_adr == `CMBC_OFS_CTRL1) begin
        st_nxt.cap_en = wd[`CMBC_BIT_CAP];
        st_nxt.map_window_select = wd[`CMBC_BIT_WIN];
      end
      if (i_wb_adr == `CMBC_OFS_CTRL2) begin
        st_nxt.data_compare_count = wd[4:0];
      end
      if (i_wb_adr == `CMBC_OFS_FCTRL) begin
        st_nxt.fifo_start_buffer = wd[5:0];
      end
    end

    // hardware clear once nothing is pending; a software set wins
    if (st_r.abort && i_tx_pending == '0) begin
      st_nxt.abort = 1'b0;
    end
    if (wr_hi && i_wb_adr == `CMBC_OFS_CTRL1 && wd[`CMBC_BIT_ABORT]) begin
      st_nxt.abort = 1'b1;
    end

    // mode switch waits for bus idle, reserved codes never take effect
    if (st_r.req != st_r.cur && !mode_reserved(st_r.req) && bus_idle) begin
      st_nxt.cur = st_r.req;
    end

    st_nxt.halt = st_r.stop_idle && i_cpu_idle;

    st_nxt.cap_evt = st_r.cap_en && i_rx_msg_done;

    // only frames that passed the error check may report a filter hit
    if (i_hit_valid && i_msg_ok) begin
      st_nxt.hit = {1'b0, i_hit_num};
    end

    st_nxt.interrupt_code = interrupt_code_of(i_err_irq, i_wake_irq, i_ovf_irq,
                            i_fifo_irq, i_buf_irq);

    // listen and configuration modes must never drive the bus
    st_nxt.rtr_req = i_rx_msg_done && i_msg_ok && i_rx_rtr &&
                     (st_r.cur == `CMBC_MODE_NORMAL ||
                      st_r.cur == `CMBC_MODE_LOOP);

    if (i_rx_msg_done) begin
      st_nxt.rx_len = (i_rx_dlc > `CMBC_MAX_DLC) ? `CMBC_MAX_DLC
                                                 : i_rx_dlc;
    end

    st_nxt.wake_evt = wk.wake;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= '0;
      st_r.rx_s1 <= 1'b1;
      st_r.rx_s2 <= 1'b1;
      st_r.req <= `CMBC_MODE_CFG;
      st_r.cur <= `CMBC_MODE_CFG;
      st_r.interrupt_code <= `CMBC_IC_NONE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // count and start fields feed the buffer logic as registered levels
  logic [4:0] cmp_bits_r;
  logic [5:0] buf_cnt_r;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cmp_bits_r <= 5'h00;
      buf_cnt_r <= 6'h04;
    end else begin
      cmp_bits_r <= (st_nxt.data_compare_count > `CMBC_DATA_COMPARE_COUNT_MAX) ? 5'h00
                                                     : st_nxt.data_compare_count;
      buf_cnt_r <= buf_count_of(st_nxt.dma_buffer_count);
    end
  end

  assign wk.rx_level = st_r.rx_s2;
  // the filter only listens while the controller sleeps in disable mode
  assign wk.arm = (st_r.cur == `CMBC_MODE_DIS);

  cmbc_wake_filter #(
    .WAKE_LEN (WAKE_LEN)
  ) u_wake (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .wk    (wk)
  );

  assign o_wb_dat        = {16'h0000, st_r.rdat};
  assign o_wb_ack        = st_r.ack;
  assign o_current_mode  = st_r.cur;
  assign o_halt          = st_r.halt;
  assign o_abort_all     = st_r.abort;
  assign o_clk_double    = st_r.clk_dbl;
  assign o_capture_evt   = st_r.cap_evt;
  assign o_window_filter = st_r.map_window_select;
  assign o_compare_bits  = cmp_bits_r;
  assign o_buffer_count  = buf_cnt_r;
  assign o_fifo_start    = st_r.fifo_start_buffer;
  assign o_rtr_reply     = st_r.rtr_req;
  assign o_rx_len        = st_r.rx_len;
  assign o_wake_evt      = st_r.wake_evt;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_mode_needs_idle: assert property (
    $changed(st_r.cur) |-> $past(bus_idle))
    else $error("mode changed without bus idle");

  a_mode_follows_req: assert property (
    $changed(st_r.cur) |-> st_r.cur == $past(st_r.req) &&
                           !mode_reserved(st_r.cur))
    else $error("mode not taken from a legal request");

  a_mode_legal: assert property (
    !mode_reserved(o_current_mode))
    else $error("current mode holds a reserved code");

  a_abort_clears: assert property (
    st_r.abort && i_tx_pending == '0 && !wr_hi |=> !o_abort_all)
    else $error("abort not cleared after all aborted");

  a_halt_idle: assert property (
    i_cpu_idle && st_r.stop_idle |=> o_halt)
    else $error("halt missing in idle");

  a_capture_link: assert property (
    o_capture_evt |-> $past(st_r.cap_en && i_rx_msg_done))
    else $error("capture event without enabled receive");

  a_interrupt_code_none: assert property (
    !i_err_irq && !i_wake_irq && !i_ovf_irq && !i_fifo_irq &&
    i_buf_irq == '0 |=> st_r.interrupt_code == `CMBC_IC_NONE)
    else $error("interrupt code not none when idle");

  a_cmp_valid: assert property (
    o_compare_bits <= `CMBC_DATA_COMPARE_COUNT_MAX)
    else $error("compare count above limit");

  a_hit_range: assert property (
    !st_r.hit[4])
    else $error("filter hit above fifteen");

  a_ack_single: assert property (
    o_wb_ack |=> !o_wb_ack)
    else $error("ack held more than one cycle");

  c_mode_change: cover property ($changed(st_r.cur));
  c_abort_done: cover property ($fell(o_abort_all));
  c_capture: cover property (o_capture_evt);
  c_rtr_reply: cover property (o_rtr_reply);

endmodule
`default_nettype wire

// ==== verification/cmbc_bus_node_model.sv ====
// behavioural far side of the bus: bit ticks, frames and a dominant hold
`timescale 1ns/100ps
`default_nettype none
module cmbc_bus_node_model #(
  parameter int TICK_DIV = 4
) (
  input  wire logic i_clk,
  input  wire logic i_busy,
  input  wire logic i_dominant,
  output logic      o_can_rx,
  output logic      o_bit_tick
);
  int unsigned div_r = 0;
  logic        bit_r = 1'b1;
  initial begin
    o_can_rx = 1'b1;
    o_bit_tick = 1'b0;
  end
  always @(posedge i_clk) begin
    div_r <= (div_r == TICK_DIV - 1) ? 0 : div_r + 1;
    o_bit_tick <= (div_r == TICK_DIV - 1);
    if (div_r == TICK_DIV - 1) begin
      bit_r <= ~bit_r;
    end
    // a released bus floats back to recessive
    o_can_rx <= i_dominant ? 1'b0 : (i_busy ? bit_r : 1'b1);
  end
endmodule
`default_nettype wire

// ==== verification/cmbc_ctrl_tb_top.sv ====
// self-checking bench of the mode and buffer control block
`timescale 1ns/100ps
`default_nettype none
`include "cmbc_consts.svh"
module cmbc_ctrl_tb_top
  import cmbc_pkg::*;
;
  logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, done = 0;
  logic        ok = 1, rtr = 0, cpu_idle = 0, hit_v = 0, busy = 0, dom = 0;
  logic [7:0]  adr = 0, pend = 0;
  logic [31:0] wdat = 0, rdat;
  logic [3:0]  sel = 0, dlc = 0, hit_n = 0, irqs = 0;
  logic [15:0] bufirq = 0;
  logic        ack, rx, tick, halt, abrt, dbl, cap, map_window_select, rtrr, wake;
  logic [2:0]  cur;
  logic [4:0]  cmpb, fs;
  logic [5:0]  bcnt, fst;
  logic [3:0]  rlen;
  logic [6:0]  ic;
  logic [32:0] mon_e;
  logic [32:0] rq[$];
  int          err_count = 0, n_compared = 0, n_cap = 0, n_rtr = 0;
  int          n_wake = 0, exp_rtr = 0, b;
  logic [2:0]  modes [0:5] = '{3'h7, 3'h3, 3'h2, 3'h1, 3'h0, 3'h4};
  logic [4:0]  dn [0:4] = '{5'h00, 5'h01, 5'h11, 5'h12, 5'h1F};
  logic [5:0]  bufs [0:6] = '{6'h04, 6'h06, 6'h08, 6'h0C, 6'h10, 6'h18, 6'h20};

  always #25 clk = ~clk;

  cmbc_bus_node_model node_u (.i_clk(clk), .i_busy(busy), .i_dominant(dom),
    .o_can_rx(rx), .o_bit_tick(tick));
  cmbc_ctrl dut_u (.i_clk(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_can_rx(rx), .i_bit_tick(tick),
    .i_cpu_idle(cpu_idle), .i_tx_pending(pend), .i_rx_msg_done(done),
    .i_msg_ok(ok), .i_rx_rtr(rtr), .i_rx_dlc(dlc), .i_hit_valid(hit_v),
    .i_hit_num(hit_n), .i_buf_irq(bufirq), .i_err_irq(irqs[3]),
    .i_wake_irq(irqs[2]), .i_ovf_irq(irqs[1]), .i_fifo_irq(irqs[0]),
    .o_current_mode(cur), .o_halt(halt), .o_abort_all(abrt),
    .o_clk_double(dbl), .o_capture_evt(cap), .o_window_filter(map_window_select),
    .o_compare_bits(cmpb), .o_buffer_count(bcnt), .o_fifo_start(fst),
    .o_rtr_reply(rtrr), .o_rx_len(rlen), .o_wake_evt(wake));

  task automatic cmp_out(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
    cmp_out(got, exp);
  endtask

  // the partner's view: expected read data is noted when the request goes out
  task automatic wb(input logic [7:0] a, input logic [31:0] d, input logic w,
                    input logic [32:0] e);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'h3;
    rq.push_back(e);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) err_count++;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(a, d, 1'b1, 33'h0_0000_0000);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(a, 32'h0000_0000, 1'b0, {1'b1, e});
  endtask
  // a mode change needs eleven idle bits, so every request waits it out
  task automatic mode(input logic [2:0] m, input logic [15:0] hi);
    wr(`CMBC_OFS_CTRL1, {16'h0000, hi | {5'h00, m, 8'h00}});
    repeat (70) @(posedge clk);
  endtask
  task automatic msg(input logic r, input logic [3:0] l);
    @(posedge clk);
    done <= 1'b1;
    rtr <= r;
    dlc <= l;
    exp_rtr += r;
    @(posedge clk);
    done <= 1'b0;
    repeat (2) @(posedge clk);
    cmp_out(rlen, (l > 4'h8) ? 4'h8 : l);
  endtask
  task automatic print_verdict();
    $display("errors=%0d compared=%0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    if (ack === 1'b1) begin
      mon_e = rq.pop_front();
      if (mon_e[32]) cmp_rd(rdat, mon_e[31:0]);
    end
    if (cap === 1'b1) n_cap++;
    if (rtrr === 1'b1) n_rtr++;
    if (wake === 1'b1) n_wake++;
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    print_verdict();
  end

  initial begin
    void'($urandom(32'h8b996c2e));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(`CMBC_OFS_CTRL1, 32'h0000_0480);
    cmp_out(cur, 32'h0000_0004);
    cmp_out(bcnt, 32'h0000_0004);
    rd(`CMBC_OFS_VEC, 32'h0000_0040);
    rd(`CMBC_OFS_FCTRL, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    busy <= 1'b1;
    // let the toggling bus break the idle run before the request lands
    repeat (12) @(posedge clk);
    wr(`CMBC_OFS_CTRL1, 32'h0000_0000);
    repeat (60) @(posedge clk);
    cmp_out(cur, 32'h0000_0004);
    busy <= 1'b0;
    repeat (32) @(posedge clk);
    cmp_out(cur, 32'h0000_0004);
    repeat (40) @(posedge clk);
    cmp_out(cur, 32'h0000_0000);
    for (int i = 0; i < 6; i++) begin
      mode(modes[i], 16'h0000);
      cmp_out(cur, modes[i]);
      rd(`CMBC_OFS_CTRL1, {21'h0, modes[i], modes[i], 5'h00});
    end
    for (int i = 5; i < 7; i++) begin
      mode(3'(i), 16'h0000);
      cmp_out(cur, 32'h0000_0004);
      rd(`CMBC_OFS_CTRL1, {21'h0, 3'(i), 3'h4, 5'h00});
    end
    mode(3'h1, 16'h0000);
    dom <= 1'b1;
    repeat (20) @(posedge clk);
    dom <= 1'b0;
    repeat (10) @(posedge clk);
    cmp_out(n_wake, 32'h0000_0001);
    pend <= 8'($urandom_range(1, 255));
    wr(`CMBC_OFS_CTRL1, 32'h0000_1100);
    repeat (3) @(posedge clk);
    cmp_out(abrt, 32'h0000_0001);
    rd(`CMBC_OFS_CTRL1, 32'h0000_1120);
    pend <= 8'h00;
    repeat (3) @(posedge clk);
    cmp_out(abrt, 32'h0000_0000);
    mode(3'h0, 16'h2809);
    cpu_idle <= 1'b1;
    repeat (3) @(posedge clk);
    cmp_out(halt, 32'h0000_0001);
    cmp_out(dbl, 32'h0000_0001);
    cmp_out(map_window_select, 32'h0000_0001);
    cpu_idle <= 1'b0;
    repeat (3) @(posedge clk);
    cmp_out(halt, 32'h0000_0000);
    for (int i = 0; i < 3; i++) msg(1'($urandom_range(0, 1)), 4'($urandom));
    wr(`CMBC_OFS_CTRL1, 32'h0000_0000);
    repeat (3) @(posedge clk);
    cmp_out({dbl, map_window_select}, 32'h0000_0000);
    for (int i = 0; i < 2; i++) msg(1'b1, 4'hF);
    cmp_out(n_cap, 32'h0000_0003);
    cmp_out(n_rtr, exp_rtr);
    for (int i = 0; i < 5; i++) begin
      wr(`CMBC_OFS_CTRL2, {27'h0, dn[i]});
      repeat (2) @(posedge clk);
      cmp_out(cmpb, (dn[i] > 5'h11) ? 5'h00 : dn[i]);
    end
    for (int i = 0; i < 7; i++) begin
      fs = 5'($urandom);
      wr(`CMBC_OFS_FCTRL, {16'h0000, 3'(i), 8'h00, fs});
      repeat (2) @(posedge clk);
      cmp_out(bcnt, bufs[i]);
      cmp_out(fst, {1'b0, fs});
    end
    wr(`CMBC_OFS_FCTRL, 32'h0000_E000);
    repeat (2) @(posedge clk);
    cmp_out(bcnt, 32'h0000_0020);
    hit_n <= 4'($urandom);
    hit_v <= 1'b1;
    @(posedge clk);
    hit_v <= 1'b0;
    @(posedge clk);
    // a hit on a frame that failed the error check must not be reported
    ok <= 1'b0;
    hit_v <= 1'b1;
    hit_n <= ~hit_n;
    @(posedge clk);
    ok <= 1'b1;
    hit_v <= 1'b0;
    hit_n <= ~hit_n;
    for (int j = 0; j < 6; j++) begin
      b = $urandom_range(0, 15);
      irqs <= 4'h8 >> j;
      bufirq <= (j == 5) ? 16'h0000 : 16'h0001 << b;
      ic = (j < 4) ? 7'h41 + 7'(j) : ((j == 4) ? 7'(b) : 7'h40);
      repeat (3) @(posedge clk);
      rd(`CMBC_OFS_VEC, {20'h0, hit_n, 1'b0, ic});
    end
    print_verdict();
  end
endmodule
`default_nettype wire
